// ### pkg/amp_params.svh
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_MODE 8'h00
`define OFS_RATE 8'h02
`define OFS_SAP 8'h03
`define OFS_CHAN_STATE 8'h04
`define OFS_FAULT 8'h05
`define OFS_DIAG 8'h06
`define OFS_MISC3 8'h21
`define OFS_ILIMIT 8'h25
`define OFS_MISC4 8'h26
// ****************************************************************
// Reset values
// ****************************************************************
`define RST_SAP 8'h04
`define RST_MISC4 8'h40
// ****************************************************************
// Field positions and codes
// ****************************************************************
`define MISC3_CLEAR 7
`define MISC3_PAR_SRC 6
`define MISC3_OT_AUTO 3
`define MISC4_BIT_CLOCK_PHASE_INVERT 3
`define SAP_FMT_TDM 2'h3
`define CHAN_STANDBY 2'h0
`define RATE_CODE_BAD 2'h3
`define CODE_MAX 3'h4
`define HOST_TARGET 2'h0
`define HOST_DATA 2'h1
`define HOST_GO 2'h2
`define HOST_STATUS 2'h3
// Upper five address bits; value is arbitrary
`define I2C_ADDR_BASE 5'h1a
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 40
`define SCL_MIN_PERIOD_NS 2500
`define I2C_QUARTER_CYCLES \
    ((`SCL_MIN_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))
`endif

// ### pkg/amp_pkg.sv
package amp_pkg;
    typedef enum logic [2:0] {
        DS_IDLE, DS_ADDR, DS_REG, DS_WRITE, DS_ACK, DS_READ, DS_RACK
    } dev_i2c_t;
    typedef enum logic {HS_IDLE, HS_RUN} host_run_t;
    typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} item_kind_t;
    typedef struct packed {
        dev_i2c_t st;
        dev_i2c_t after_ack;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic master_ack;
        logic sda_oe;
        logic scl_prev;
        logic sda_prev;
        logic [1:0] strap_age;
        logic [1:0] strap;
        logic [7:0] mode;
        logic [7:0] rate;
        logic [7:0] sap;
        logic [7:0] chan_state;
        logic [7:0] diag;
        logic [7:0] misc3;
        logic [7:0] misc4;
        logic [3:0] warn;
        logic ot_latched;
        logic [2:0] fault;
        logic clear_pulse;
        logic [5:0] sw_mult;
        logic [2:0] tdm_slot;
    } dev_state_t;
    typedef struct packed {
        host_run_t st;
        logic [2:0] item;
        logic [1:0] q;
        logic [3:0] cnt;
        logic [7:0] div;
        logic [7:0] shift;
        logic [9:0] target;
        logic [7:0] wdata;
        logic is_read;
        logic [7:0] rdata;
        logic nack;
        logic scl_oe;
        logic sda_oe;
        logic [15:0] rd_out;
    } host_state_t;
endpackage

// ### pkg/amp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface amp_link_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // Open-drain wires with pull-ups
    assign scl = host_scl_oe ? host_scl_out : 1'b1;
    assign sda = (host_sda_oe ? host_sda_out : 1'b1) &
        (dev_sda_oe ? dev_sda_out : 1'b1);
    modport host(
        input scl,
        input sda,
        output host_scl_out,
        output host_scl_oe,
        output host_sda_out,
        output host_sda_oe
    );
    modport device(
        input scl,
        input sda,
        output dev_sda_out,
        output dev_sda_oe
    );
endinterface
`default_nettype wire

// ### verilog/amp_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module amp_sync2 #(
    parameter int WIDTH = 2
) (
    // System
    input wire logic clock,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;
    sync_state_t s, next_s;

    always_comb begin
        next_s.meta = din;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.stable;
endmodule
`default_nettype wire

// ### verilog/amp_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "amp_params.svh"

// Function
// - Read-only current-limit byte, four channel flags
// - Control register 0x26 resets to 0x40
// - Bit 3 inverts same-frequency clock phase
// - Bits 2-0 pick high-pass corner
// - Switching multiple 38/44/48 or 8/10
// - Mismatched paralleled channel states raise fault
// - Parallel-bridge writes only in standby
// - Diagnostics allowed on parallel-bridge channels
// - Slave only; master starts every access
// - Master clock at most 400 kHz
// - Up to four devices, distinct strapped addresses
// - Host selects line driver via 0x00
// - I2S, RJ, LJ, TDM; 16-32 bit words
// - Sample rates 44.1, 48, 96 kHz
// - Register 0x03 bits 5-3 need TDM
// - Host configures, clears faults, checks, plays
// - Host waits for operations before reading
// - 0x21 bit 7 clears, bit 3 recovery
// - 0x21 bit 6 swaps parallel source
module amp_device (
    // System
    input wire logic clock,
    input wire logic reset,
    // Control link
    amp_link_if.device link,
    // Address strap pins
    input wire logic [1:0] addr_strap,
    // Protection events
    input wire logic [3:0] chan_current_limit,
    input wire logic overtemp_event,
    // Output stage configuration
    output logic [3:0] chan_line_driver,
    output logic [1:0] parallel_bridge_mode,
    output logic [7:0] chan_state,
    output logic [3:0] diag_request,
    output logic [5:0] switch_freq_multiple,
    output logic parallel_source_select,
    // Audio input configuration
    output logic [1:0] sample_rate_sel,
    output logic [1:0] audio_format,
    output logic [2:0] word_length_sel,
    output logic [2:0] tdm_slot_sel,
    output logic bit_clock_phase_invert,
    output logic [2:0] highpass_corner_sel,
    // Protection status
    output logic clear_fault,
    output logic overtemp_auto_recover,
    output logic [3:0] current_limit_warn,
    output logic [2:0] fault_report
);
    amp_pkg::dev_state_t s, next_s;
    logic [3:0] pins;
    logic scl_in, sda_in;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic standby, clr, load_rd, wr_en;
    logic [7:0] rd_byte;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic [7:0] read_reg(
        input amp_pkg::dev_state_t r,
        input logic [7:0] a
    );
        case (a)
            `OFS_MODE: read_reg = r.mode;
            `OFS_RATE: read_reg = r.rate;
            `OFS_SAP: read_reg = r.sap;
            `OFS_CHAN_STATE: read_reg = r.chan_state;
            `OFS_FAULT: read_reg = {5'h00, r.fault};
            `OFS_DIAG: read_reg = r.diag;
            `OFS_MISC3: read_reg = r.misc3;
            `OFS_ILIMIT: read_reg = {4'h0, r.warn};
            `OFS_MISC4: read_reg = r.misc4;
            default: read_reg = 8'h00;
        endcase
    endfunction

    function automatic logic [5:0] swf_mult(input logic [2:0] code);
        case (code)
            3'h0: swf_mult = 6'h26;
            3'h1: swf_mult = 6'h2c;
            3'h2: swf_mult = 6'h30;
            3'h3: swf_mult = 6'h08;
            default: swf_mult = 6'h0a;
        endcase
    endfunction

    // ****************************************************************
    // Pin conditioning
    // ****************************************************************
    amp_sync2 #(.WIDTH(4)) pin_sync (
        .clock(clock),
        .reset(reset),
        .din({link.scl, link.sda, addr_strap}),
        .dout(pins)
    );
    assign scl_in = pins[3];
    assign sda_in = pins[2];
    assign scl_rise = scl_in & ~s.scl_prev;
    assign scl_fall = ~scl_in & s.scl_prev;
    assign start_cond = scl_in & s.scl_prev & s.sda_prev & ~sda_in;
    assign stop_cond = scl_in & s.scl_prev & ~s.sda_prev & sda_in;
    assign standby = s.chan_state == {4{`CHAN_STANDBY}};
    assign clr = s.clear_pulse;
    assign rd_byte = read_reg(s, s.ptr);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        wr_en = 1'b0;
        load_rd = 1'b0;
        next_s.scl_prev = scl_in;
        next_s.sda_prev = sda_in;
        next_s.clear_pulse = 1'b0;
        // strap caught once synchroniser has filled
        if (s.strap_age != 2'h3) begin
            next_s.strap_age = s.strap_age + 2'h1;
            next_s.strap = pins[1:0];
        end
        // only ever answers, never drives the clock
        if (start_cond) begin
            next_s.st = amp_pkg::DS_ADDR;
            next_s.cnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_s.st = amp_pkg::DS_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            unique case (s.st)
                amp_pkg::DS_IDLE: begin
                end
                amp_pkg::DS_ADDR, amp_pkg::DS_REG, amp_pkg::DS_WRITE: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], sda_in};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (scl_fall && s.cnt == 4'h8) begin
                        next_s.cnt = 4'h0;
                        next_s.st = amp_pkg::DS_ACK;
                        next_s.sda_oe = 1'b1;
                        next_s.after_ack = amp_pkg::DS_WRITE;
                        if (s.st == amp_pkg::DS_ADDR) begin
                            next_s.after_ack = s.shift[0] ?
                                amp_pkg::DS_READ : amp_pkg::DS_REG;
                            if (s.shift[7:1] != {`I2C_ADDR_BASE, s.strap})
                            begin
                                next_s.st = amp_pkg::DS_IDLE;
                                next_s.sda_oe = 1'b0;
                            end
                        end else if (s.st == amp_pkg::DS_REG) begin
                            next_s.ptr = s.shift;
                        end else begin
                            wr_en = 1'b1;
                            next_s.ptr = s.ptr + 8'h01;
                        end
                    end
                end
                amp_pkg::DS_ACK: begin
                    if (scl_fall) begin
                        next_s.st = s.after_ack;
                        next_s.sda_oe = 1'b0;
                        load_rd = s.after_ack == amp_pkg::DS_READ;
                    end
                end
                amp_pkg::DS_READ: begin
                    if (scl_fall && s.cnt == 4'h8) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = amp_pkg::DS_RACK;
                    end else if (scl_fall) begin
                        next_s.shift = {s.shift[6:0], 1'b0};
                        next_s.sda_oe = ~s.shift[6];
                        next_s.cnt = s.cnt + 4'h1;
                    end
                end
                amp_pkg::DS_RACK: begin
                    if (scl_rise) begin
                        next_s.master_ack = ~sda_in;
                    end else if (scl_fall) begin
                        next_s.st = s.master_ack ?
                            amp_pkg::DS_READ : amp_pkg::DS_IDLE;
                        load_rd = s.master_ack;
                    end
                end
            endcase
        end
        // reading any register has no side effect
        if (load_rd) begin
            next_s.shift = rd_byte;
            next_s.sda_oe = ~rd_byte[7];
            next_s.cnt = 4'h1;
            next_s.ptr = s.ptr + 8'h01;
        end
        if (wr_en) begin
            case (s.ptr)
                `OFS_MODE: begin
                    next_s.mode = standby ? s.shift :
                        {s.shift[7:6], s.mode[5:4], s.shift[3:0]};
                end
                `OFS_RATE: begin
                    // undefined codes keep the old setting
                    next_s.rate[5:4] = s.shift[5:4] == `RATE_CODE_BAD ?
                        s.rate[5:4] : s.shift[5:4];
                    next_s.rate[2:0] = s.shift[2:0] > `CODE_MAX ?
                        s.rate[2:0] : s.shift[2:0];
                end
                `OFS_SAP: begin
                    next_s.sap[7:3] = s.shift[7:3];
                    next_s.sap[2:0] = s.shift[2:0] > `CODE_MAX ?
                        s.sap[2:0] : s.shift[2:0];
                end
                `OFS_CHAN_STATE: next_s.chan_state = s.shift;
                // diagnostics not gated by bridge mode
                `OFS_DIAG: next_s.diag = {4'h0, s.shift[3:0]};
                `OFS_MISC3: begin
                    next_s.misc3 = {1'b0, s.shift[6:3], 3'h0};
                    next_s.clear_pulse = s.shift[`MISC3_CLEAR];
                end
                `OFS_MISC4: next_s.misc4 = s.shift;
                default: begin
                end
            endcase
        end
        next_s.warn = (clr ? 4'h0 : s.warn) | chan_current_limit;
        next_s.ot_latched = s.misc3[`MISC3_OT_AUTO] ? overtemp_event :
            ((clr ? 1'b0 : s.ot_latched) | overtemp_event);
        // paralleled pair must share one state
        next_s.fault[0] = s.mode[4] & (s.chan_state[1:0] != s.chan_state[3:2]);
        next_s.fault[1] = s.mode[5] & (s.chan_state[5:4] != s.chan_state[7:6]);
        next_s.fault[2] = s.ot_latched;
        next_s.sw_mult = swf_mult(s.rate[2:0]);
        next_s.tdm_slot = s.sap[7:6] == `SAP_FMT_TDM ? s.sap[5:3] : 3'h0;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
            s.sap <= `RST_SAP;
            s.misc4 <= `RST_MISC4;
            s.sw_mult <= 6'h26;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.dev_sda_out = 1'b0;
    assign link.dev_sda_oe = s.sda_oe;
    // line driver bits steer the output stage
    assign chan_line_driver = s.mode[3:0];
    assign parallel_bridge_mode = s.mode[5:4];
    assign chan_state = s.chan_state;
    assign diag_request = s.diag[3:0];
    assign switch_freq_multiple = s.sw_mult;
    assign parallel_source_select = s.misc3[`MISC3_PAR_SRC];
    assign sample_rate_sel = s.rate[5:4];
    assign audio_format = s.sap[7:6];
    assign word_length_sel = s.sap[2:0];
    assign tdm_slot_sel = s.tdm_slot;
    assign bit_clock_phase_invert = s.misc4[`MISC4_BIT_CLOCK_PHASE_INVERT];
    assign highpass_corner_sel = s.misc4[2:0];
    assign clear_fault = s.clear_pulse;
    assign overtemp_auto_recover = s.misc3[`MISC3_OT_AUTO];
    assign current_limit_warn = s.warn;
    assign fault_report = s.fault;
endmodule
`default_nettype wire

// ### verilog/amp_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "amp_params.svh"
module amp_host #(
    parameter logic [7:0] QUARTER_CYCLES = 8'(`I2C_QUARTER_CYCLES)
) (
    // System
    input wire logic clock,
    input wire logic reset,
    // Control link
    amp_link_if.host link,
    // Command port
    input wire logic [1:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_write,
    input wire logic cmd_read,
    output logic [15:0] cmd_rdata
);
    amp_pkg::host_state_t s, next_s;
    logic [1:0] pins;
    logic tick;
    logic [1:0] drv;
    amp_pkg::item_kind_t kind;

    function automatic amp_pkg::item_kind_t kind_of(
        input logic [2:0] item,
        input logic rd
    );
        if (item == 3'h0 || (rd && item == 3'h3)) begin
            kind_of = amp_pkg::K_START;
        end else if (item == (rd ? 3'h6 : 3'h4)) begin
            kind_of = amp_pkg::K_STOP;
        end else if (rd && item == 3'h5) begin
            kind_of = amp_pkg::K_RX;
        end else begin
            kind_of = amp_pkg::K_TX;
        end
    endfunction

    // Returns {scl_oe, sda_oe} for a quarter of a bit
    function automatic logic [1:0] drive(
        input amp_pkg::host_state_t h
    );
        logic [7:0] b;
        b = h.item == 3'h1 ? {`I2C_ADDR_BASE, h.target[9:8], 1'b0} :
            h.item == 3'h2 ? h.target[7:0] :
            h.is_read ? {`I2C_ADDR_BASE, h.target[9:8], 1'b1} : h.wdata;
        b = b << h.cnt[2:0];
        unique case (kind_of(h.item, h.is_read))
            amp_pkg::K_START: drive = {h.q == 2'h0 || h.q == 2'h3, h.q[1]};
            amp_pkg::K_STOP: drive = {h.q == 2'h0, ~h.q[1]};
            amp_pkg::K_TX: drive = {~h.q[1], h.cnt != 4'h8 && !b[7]};
            amp_pkg::K_RX: drive = {~h.q[1], 1'b0};
        endcase
    endfunction

    amp_sync2 #(.WIDTH(2)) pin_sync (
        .clock(clock),
        .reset(reset),
        .din({link.scl, link.sda}),
        .dout(pins)
    );
    assign kind = kind_of(s.item, s.is_read);
    // quarter length keeps the clock within 400 kHz
    assign tick = s.st == amp_pkg::HS_RUN && s.div == QUARTER_CYCLES - 8'h01;

    always_comb begin
        next_s = s;
        drv = 2'h0;
        next_s.rd_out = 16'h0000;
        if (cmd_read) begin
            case (cmd_addr)
                `HOST_TARGET: next_s.rd_out = {6'h00, s.target};
                `HOST_DATA: next_s.rd_out = {8'h00, s.wdata};
                `HOST_STATUS: next_s.rd_out = {6'h00, s.nack,
                    s.st == amp_pkg::HS_RUN, s.rdata};
                default: next_s.rd_out = 16'h0000;
            endcase
        end
        // configuration held and commands refused while busy
        if (cmd_write && s.st == amp_pkg::HS_IDLE) begin
            case (cmd_addr)
                `HOST_TARGET: next_s.target = cmd_wdata[9:0];
                `HOST_DATA: next_s.wdata = cmd_wdata[7:0];
                `HOST_GO: begin
                    next_s.st = amp_pkg::HS_RUN;
                    next_s.is_read = cmd_wdata[0];
                    next_s.item = 3'h0;
                    next_s.q = 2'h0;
                    next_s.cnt = 4'h0;
                    next_s.div = 8'h00;
                    next_s.nack = 1'b0;
                    next_s.scl_oe = 1'b1;
                    next_s.sda_oe = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (s.st == amp_pkg::HS_RUN) begin
            next_s.div = tick ? 8'h00 : s.div + 8'h01;
        end
        if (tick) begin
            if (s.q == 2'h2 && kind == amp_pkg::K_TX && s.cnt == 4'h8) begin
                next_s.nack = s.nack | pins[0];
            end
            if (s.q == 2'h2 && kind == amp_pkg::K_RX && s.cnt != 4'h8) begin
                next_s.shift = {s.shift[6:0], pins[0]};
            end
            next_s.q = s.q + 2'h1;
            if (s.q == 2'h3) begin
                if ((kind == amp_pkg::K_TX || kind == amp_pkg::K_RX) &&
                    s.cnt != 4'h8) begin
                    next_s.cnt = s.cnt + 4'h1;
                end else begin
                    next_s.cnt = 4'h0;
                    if (kind == amp_pkg::K_RX) begin
                        next_s.rdata = s.shift;
                    end
                    if (kind == amp_pkg::K_STOP) begin
                        next_s.st = amp_pkg::HS_IDLE;
                    end else if (s.nack) begin
                        // Refused byte: go straight to stop
                        next_s.item = s.is_read ? 3'h6 : 3'h4;
                    end else begin
                        next_s.item = s.item + 3'h1;
                    end
                end
            end
            drv = drive(next_s);
            next_s.scl_oe = next_s.st == amp_pkg::HS_RUN && drv[1];
            next_s.sda_oe = next_s.st == amp_pkg::HS_RUN && drv[0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.host_scl_out = 1'b0;
    assign link.host_sda_out = 1'b0;
    assign link.host_scl_oe = s.scl_oe;
    assign link.host_sda_oe = s.sda_oe;
    assign cmd_rdata = s.rd_out;
endmodule
`default_nettype wire

// ### verification/amp_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module amp_link_props (
    // System
    input wire logic clock,
    input wire logic reset,
    // Link
    input wire logic scl,
    input wire logic sda,
    input wire logic host_scl_out,
    input wire logic host_scl_oe,
    input wire logic host_sda_out,
    input wire logic host_sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe
);
    logic framed;
    logic [5:0] high_run;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    always_ff @(posedge clock) begin
        if (reset) begin
            framed <= 1'b0;
            high_run <= 6'h3f;
        end else begin
            // Data only moves under high clock at start or stop
            if (scl && $changed(sda)) begin
                framed <= !sda;
            end
            high_run <= !scl ? 6'h00 : high_run + 6'(high_run != 6'h3f);
        end
    end
    a_data_one_owner: assert property (scl && dev_sda_oe |->
        !host_sda_oe && !dev_sda_out)
        else $error("data driven by both ends");
    a_host_idle_after: assert property (scl && $rose(sda) |=>
        (!host_scl_oe && !host_scl_out && !host_sda_out) [*8])
        else $error("host busy after stop");
    a_reset_quiet: assert property ($fell(reset) |->
        !host_scl_oe && !host_sda_oe && !dev_sda_oe)
        else $error("line driven after reset");
    a_dev_scl_low: assert property ($changed(dev_sda_oe) |->
        !scl && !$past(scl))
        else $error("device moved data under high clock");
    a_scl_high_min: assert property ($fell(scl) |-> high_run >= 6'h0f)
        else $error("clock high phase too short");
    a_dev_in_frame: assert property (dev_sda_oe |-> framed)
        else $error("device drove data outside a frame");
    a_dev_bit_hold: assert property ($rose(dev_sda_oe) |=>
        dev_sda_oe [*8])
        else $error("device data drive dropped early");
    a_stop_release: assert property (scl && $rose(sda) |=>
        !dev_sda_oe [*4])
        else $error("device drove data after stop");
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property (scl && $fell(sda));
    c_stop: cover property (scl && $rose(sda));
endmodule
`default_nettype wire

// ### verification/amp_control_status_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "amp_params.svh"
module amp_control_status_regs_tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [1:0] cmd_addr = 2'h0;
    logic [15:0] cmd_wdata = 16'h0;
    logic cmd_write = 1'b0;
    logic cmd_read = 1'b0;
    logic [15:0] cmd_rdata, st;
    logic [3:0] ilim = 4'h0;
    logic otemp = 1'b0;
    logic [1:0] strap = 2'h2;
    logic [5:0] mult;
    logic [1:0] bridge, rsel;
    logic [2:0] fault, corner, slot;
    logic inv, psrc, otauto;
    logic [3:0] lined;
    logic [7:0] v;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 32'h9ae938c1;
    int mtab[5] = '{38, 44, 48, 8, 10};
    amp_link_if link();
    amp_host u_amp_host(.clock(clock), .reset(reset), .link(link.host),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write),
        .cmd_read(cmd_read), .cmd_rdata(cmd_rdata));
    amp_device u_amp_device(.clock(clock), .reset(reset), .link(link.device),
        .addr_strap(strap), .chan_current_limit(ilim), .overtemp_event(otemp),
        .chan_line_driver(lined), .parallel_bridge_mode(bridge),
        .chan_state(), .diag_request(), .switch_freq_multiple(mult),
        .parallel_source_select(psrc), .sample_rate_sel(rsel),
        .audio_format(), .word_length_sel(), .tdm_slot_sel(slot),
        .bit_clock_phase_invert(inv), .highpass_corner_sel(corner),
        .clear_fault(), .overtemp_auto_recover(otauto),
        .current_limit_warn(), .fault_report(fault));
    amp_link_props u_props(.clock(clock), .reset(reset), .scl(link.scl),
        .sda(link.sda), .host_scl_out(link.host_scl_out),
        .host_scl_oe(link.host_scl_oe), .host_sda_out(link.host_sda_out),
        .host_sda_oe(link.host_sda_oe), .dev_sda_out(link.dev_sda_out),
        .dev_sda_oe(link.dev_sda_oe));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One strobe cycle; read data stands in the following cycle
    task automatic cmd(input logic [1:0] a, input logic [15:0] d,
        input logic rd);
        @(posedge clock);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_write <= !rd;
        cmd_read <= rd;
        @(posedge clock);
        cmd_write <= 1'b0;
        cmd_read <= 1'b0;
        #1 st = cmd_rdata;
    endtask
    task automatic xfer(input logic [1:0] s, input logic [7:0] ofs,
        input logic [7:0] d, input logic rd);
        cmd(2'h0, {6'h0, s, ofs}, 1'b0);
        cmd(2'h1, {8'h0, d}, 1'b0);
        cmd(2'h2, {15'h0, rd}, 1'b0);
        for (int i = 0; i < 4000; i++) begin
            cmd(2'h3, 16'h0, 1'b1);
            if (st[8] === 1'b0) return;
        end
        $display("wrong value at %0t: transfer hung", $time);
        n_mismatch++;
        print_verdict();
    endtask
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (8) @(posedge clock);
        xfer(strap, `OFS_MISC4, 8'h00, 1'b1);
        check(st[7:0], `RST_MISC4);
        xfer(strap, `OFS_ILIMIT, 8'h00, 1'b1);
        check(st[7:0], 8'h00);
        $display("test reset values done");
        for (int c = 0; c < 8; c++) begin
            v = 8'($random(seed));
            v[2:0] = 3'(c);
            xfer(strap, `OFS_MISC4, v, 1'b0);
            xfer(strap, `OFS_MISC4, 8'h00, 1'b1);
            check(st[7:0], v);
            check({4'h0, inv, corner}, {4'h0, v[3:0]});
        end
        for (int c = 0; c < 5; c++) begin
            xfer(strap, `OFS_RATE, 8'(c), 1'b0);
            check({2'h0, mult}, 8'(mtab[c]));
        end
        xfer(strap, `OFS_RATE, 8'h27, 1'b0);
        check({rsel, mult}, 8'h8a);
        xfer(strap, `OFS_SAP, 8'hea, 1'b0);
        check({5'h0, slot}, 8'h05);
        xfer(strap, `OFS_SAP, 8'h2f, 1'b0);
        xfer(strap, `OFS_SAP, 8'h00, 1'b1);
        check({slot, st[4:0]}, 8'h0a);
        $display("test control fields done");
        v = 8'($random(seed)) | 8'h01;
        @(posedge clock);
        ilim <= v[3:0];
        otemp <= 1'b1;
        @(posedge clock);
        ilim <= 4'h0;
        otemp <= 1'b0;
        repeat (2) begin
            xfer(strap, `OFS_ILIMIT, 8'h00, 1'b1);
            check(st[7:0], {4'h0, v[3:0]});
        end
        check({5'h0, fault}, 8'h04);
        xfer(strap, `OFS_MISC3, 8'hc8, 1'b0);
        @(posedge clock);
        otemp <= 1'b1;
        xfer(strap, `OFS_ILIMIT, 8'h00, 1'b1);
        check(st[7:0], 8'h00);
        check({3'h0, fault, psrc, otauto}, 8'h13);
        @(posedge clock);
        otemp <= 1'b0;
        $display("test current warning done");
        xfer(strap, `OFS_CHAN_STATE, 8'h55, 1'b0);
        xfer(strap, `OFS_MODE, 8'h3a, 1'b0);
        check({2'h0, bridge, lined}, 8'h0a);
        xfer(strap, `OFS_CHAN_STATE, 8'h00, 1'b0);
        xfer(strap, `OFS_MODE, 8'h30, 1'b0);
        check({2'h0, bridge, lined}, 8'h30);
        xfer(strap, `OFS_CHAN_STATE, 8'h01, 1'b0);
        check({5'h0, fault}, 8'h01);
        xfer(strap, `OFS_DIAG, 8'hff, 1'b0);
        xfer(strap, `OFS_DIAG, 8'h00, 1'b1);
        check(st[7:0], 8'h0f);
        xfer(strap ^ 2'h1, `OFS_MISC4, 8'h00, 1'b1);
        check({7'h0, st[9]}, 8'h01);
        $display("test bridge and address done");
        print_verdict();
    end
endmodule
`default_nettype wire
